/* dtc_defs.vh */
// dtc_defs.vh: register indices, field positions, reset values
// for the dual timer/counter pair; included by the design file
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// register indices, byte address is four times the index
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_T0_LOW 8'h8a
`define DTC_IDX_T1_LOW 8'h8b
`define DTC_IDX_T0_HIGH 8'h8c
`define DTC_IDX_T1_HIGH 8'h8d
`define DTC_IDX_RUN 8'ha0
`define DTC_IDX_STAT 8'ha1
`define DTC_IDX_MASK 8'ha2

// timer_mode_control fields
`define DTC_T1_GATE 7
`define DTC_T1_SRC 6
`define DTC_T1_MODE_HI 5
`define DTC_T1_MODE_LO 4
`define DTC_T0_GATE 3
`define DTC_T0_SRC 2
`define DTC_T0_MODE_HI 1
`define DTC_T0_MODE_LO 0

// mode field encodings
`define DTC_MODE_PRESCALE 2'h0
`define DTC_MODE_FULL16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// run, status and mask bit positions
`define DTC_T0_BIT 0
`define DTC_T1_BIT 1

// reset values
`define DTC_RST_MODE 8'h00
`define DTC_RST_DATA 8'h00
`define DTC_RST_FLAGS 2'h0

// timer mode steps once every this many clock cycles
`define DTC_TIMER_DIV 2

`endif

/* dtc_timer_pair.v */
// dtc_timer_pair.v: two 8/16-bit timer/counters behind an APB slave
// assumes count and gate pins synchronous to clock; APB on clock
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "dtc_defs.vh"

module dtc_timer_pair #(
    parameter ADDR_W = 10
) (
    input wire clock,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire timer0_count_pin,
    input wire timer1_count_pin,
    input wire external_interrupt_0_pin,
    input wire external_interrupt_1_pin,
    output reg irq
);

    reg [7:0] mode_ff;
    reg [7:0] t0_low_ff;
    reg [7:0] t0_high_ff;
    reg [7:0] t1_low_ff;
    reg [7:0] t1_high_ff;
    reg [1:0] run_ff;
    reg [1:0] stat_ff;
    reg [1:0] mask_ff;
    reg phase_ff;
    reg t0_pin_ff;
    reg t1_pin_ff;

    reg [7:0] nxt_t0_low;
    reg [7:0] nxt_t0_high;
    reg [7:0] nxt_t1_low;
    reg [7:0] nxt_t1_high;
    reg [1:0] nxt_stat;
    reg [1:0] nxt_mask;
    reg [31:0] nxt_rdata;
    reg nxt_err;

    // one step of a timer in modes 00, 01, 10; returns {ovf, high, low}
    function [16:0] dtc_step;
        input [1:0] md;
        input [7:0] lo;
        input [7:0] hi;
        begin
            dtc_step = {1'b0, hi, lo};
            case (md)
                `DTC_MODE_PRESCALE: begin
                    if (lo[4:0] == 5'h1f) begin
                        dtc_step = {(hi == 8'hff), hi + 8'h01,
                            lo[7:5], 5'h00};
                    end else begin
                        dtc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                    end
                end
                `DTC_MODE_FULL16: begin
                    dtc_step = {1'b0, hi, lo} + 17'h00001;
                end
                `DTC_MODE_RELOAD: begin
                    if (lo == 8'hff) begin
                        dtc_step = {1'b1, hi, hi};
                    end else begin
                        dtc_step = {1'b0, hi, lo + 8'h01};
                    end
                end
                default: begin
                    dtc_step = {1'b0, hi, lo};
                end
            endcase
        end
    endfunction

    wire [1:0] t0_mode = mode_ff[`DTC_T0_MODE_HI:`DTC_T0_MODE_LO];
    wire [1:0] t1_mode = mode_ff[`DTC_T1_MODE_HI:`DTC_T1_MODE_LO];
    wire t0_split = (t0_mode == `DTC_MODE_SPLIT);

    // apb decode
    wire [7:0] idx = paddr[ADDR_W-1:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire setup = psel & ~penable;
    wire done = psel & penable & pready;
    wire wr = done & pwrite & ~pslverr;
    wire rd = done & ~pwrite & ~pslverr;
    wire wr_mode = wr & (idx == `DTC_IDX_MODE);
    wire wr_t0l = wr & (idx == `DTC_IDX_T0_LOW);
    wire wr_t1l = wr & (idx == `DTC_IDX_T1_LOW);
    wire wr_t0h = wr & (idx == `DTC_IDX_T0_HIGH);
    wire wr_t1h = wr & (idx == `DTC_IDX_T1_HIGH);
    wire wr_run = wr & (idx == `DTC_IDX_RUN);
    wire wr_mask = wr & (idx == `DTC_IDX_MASK);
    wire rd_stat = rd & (idx == `DTC_IDX_STAT);

    // count enables from run bit and gate
    wire t0_en = run_ff[`DTC_T0_BIT] &
        (~mode_ff[`DTC_T0_GATE] | external_interrupt_0_pin);
    wire t1_en = run_ff[`DTC_T1_BIT] &
        (~mode_ff[`DTC_T1_GATE] | external_interrupt_1_pin);

    // count pin falling edges
    wire t0_fall = t0_pin_ff & ~timer0_count_pin;
    wire t1_fall = t1_pin_ff & ~timer1_count_pin;

    // source select: divided clock or count pin
    wire t0_src = mode_ff[`DTC_T0_SRC] ? t0_fall : phase_ff;
    wire t1_src = mode_ff[`DTC_T1_SRC] ? t1_fall : phase_ff;
    wire t0_tick = t0_en & t0_src;
    wire t1_tick = t1_en & t1_src;
    // split high byte steps on the divided clock, gated by timer1 run bit
    wire t0h_tick = run_ff[`DTC_T1_BIT] & phase_ff;

    wire [16:0] t0_next = dtc_step(t0_mode, t0_low_ff, t0_high_ff);
    wire [16:0] t1_next = dtc_step(t1_mode, t1_low_ff, t1_high_ff);

    // counters; a software write wins over a step in the same cycle
    always @* begin
        nxt_t0_low = t0_low_ff;
        nxt_t0_high = t0_high_ff;
        nxt_t1_low = t1_low_ff;
        nxt_t1_high = t1_high_ff;
        nxt_stat = stat_ff;
        if (rd_stat) begin
            nxt_stat = `DTC_RST_FLAGS;
        end
        if (t0_split) begin
            if (t0_tick) begin
                nxt_t0_low = t0_low_ff + 8'h01;
                if (t0_low_ff == 8'hff) begin
                    nxt_stat[`DTC_T0_BIT] = 1'b1;
                end
            end
            if (t0h_tick) begin
                nxt_t0_high = t0_high_ff + 8'h01;
                if (t0_high_ff == 8'hff) begin
                    nxt_stat[`DTC_T1_BIT] = 1'b1;
                end
            end
        end else if (t0_tick) begin
            nxt_t0_high = t0_next[15:8];
            nxt_t0_low = t0_next[7:0];
            if (t0_next[16]) begin
                nxt_stat[`DTC_T0_BIT] = 1'b1;
            end
        end
        // mode 11 is held by the step function
        if (t1_tick) begin
            nxt_t1_high = t1_next[15:8];
            nxt_t1_low = t1_next[7:0];
            if (t1_next[16] & ~t0_split) begin
                nxt_stat[`DTC_T1_BIT] = 1'b1;
            end
        end
        if (wr_t0l) begin
            nxt_t0_low = pwdata[7:0];
        end
        if (wr_t0h) begin
            nxt_t0_high = pwdata[7:0];
        end
        if (wr_t1l) begin
            nxt_t1_low = pwdata[7:0];
        end
        if (wr_t1h) begin
            nxt_t1_high = pwdata[7:0];
        end
    end

    always @* begin
        nxt_mask = mask_ff;
        if (wr_mask) begin
            nxt_mask = pwdata[1:0];
        end
    end

    // read mux, latched in the setup cycle
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b0;
        if (!aligned) begin
            nxt_err = 1'b1;
        end else begin
            case (idx)
                `DTC_IDX_MODE: begin
                    nxt_rdata[7:0] = mode_ff;
                end
                `DTC_IDX_T0_LOW: begin
                    nxt_rdata[7:0] = t0_low_ff;
                end
                `DTC_IDX_T1_LOW: begin
                    nxt_rdata[7:0] = t1_low_ff;
                end
                `DTC_IDX_T0_HIGH: begin
                    nxt_rdata[7:0] = t0_high_ff;
                end
                `DTC_IDX_T1_HIGH: begin
                    nxt_rdata[7:0] = t1_high_ff;
                end
                `DTC_IDX_RUN: begin
                    nxt_rdata[1:0] = run_ff;
                end
                `DTC_IDX_STAT: begin
                    nxt_rdata[1:0] = stat_ff;
                end
                `DTC_IDX_MASK: begin
                    nxt_rdata[1:0] = mask_ff;
                end
                default: begin
                    nxt_err = 1'b1;
                end
            endcase
        end
    end

    // read data loaded in setup, held until the next setup
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= nxt_rdata;
        end
    end

    // one access cycle after every setup
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
        end else if (done) begin
            pready <= 1'b0;
        end
    end

    // error flag travels with pready
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= nxt_err;
        end else if (done) begin
            pslverr <= 1'b0;
        end
    end

    // mode register
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= `DTC_RST_MODE;
        end else if (wr_mode) begin
            mode_ff <= pwdata[7:0];
        end
    end

    // run bits
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_ff <= 2'h0;
        end else if (wr_run) begin
            run_ff <= pwdata[1:0];
        end
    end

    // timer0 low byte
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t0_low_ff <= `DTC_RST_DATA;
        end else begin
            t0_low_ff <= nxt_t0_low;
        end
    end

    // timer0 high byte
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t0_high_ff <= `DTC_RST_DATA;
        end else begin
            t0_high_ff <= nxt_t0_high;
        end
    end

    // timer1 low byte
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t1_low_ff <= `DTC_RST_DATA;
        end else begin
            t1_low_ff <= nxt_t1_low;
        end
    end

    // timer1 high byte
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t1_high_ff <= `DTC_RST_DATA;
        end else begin
            t1_high_ff <= nxt_t1_high;
        end
    end

    // sticky overflow flags
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_ff <= `DTC_RST_FLAGS;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // interrupt mask
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_ff <= `DTC_RST_FLAGS;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // irq follows the next flags so it rises with the overflow
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(nxt_stat & nxt_mask);
        end
    end

    // divide-by-two phase for timer mode
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    // previous pin levels, idle high so reset gives no false edge
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t0_pin_ff <= 1'b1;
        end else begin
            t0_pin_ff <= timer0_count_pin;
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            t1_pin_ff <= 1'b1;
        end else begin
            t1_pin_ff <= timer1_count_pin;
        end
    end

endmodule // dtc_timer_pair

/* dtc_chk.sv */
// dtc_chk.sv: port checker for dtc_timer_pair, bound at the foot
// assumes one clock, nrst async active low, apb one access cycle
`timescale 1ns/100ps
module dtc_chk #(
    parameter ADDR_W = 10
) (
    input wire clock,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire timer0_count_pin,
    input wire timer1_count_pin,
    input wire external_interrupt_0_pin,
    input wire external_interrupt_1_pin,
    input wire irq
);
    logic [1:0] mask_ff;
    wire done = psel && penable && pready && !pslverr;
    wire clr = done && (paddr == 10'h284 || paddr == 10'h288);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // shadow of the mask register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            mask_ff <= 2'h0;
        else if (done && pwrite && paddr == 10'h288)
            mask_ff <= pwdata[1:0];
    end
    rdy_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    rdy_single_a: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    err_align_a: assert property (psel && !penable &&
        paddr[1:0] != 2'h0 |=> pslverr && pready)
        else $error("misaligned access not refused");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_hold_a: assert property (!(psel && !penable) |=>
        $stable(prdata))
        else $error("prdata changed outside setup");
    rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    irq_mask_a: assert property (mask_ff == 2'h0 &&
        $past(mask_ff) == 2'h0 |-> !irq)
        else $error("irq high with mask clear");
    irq_keep_a: assert property (irq && !clr |=> irq)
        else $error("irq dropped without clear");
endmodule // dtc_chk

bind dtc_timer_pair dtc_chk #(.ADDR_W(ADDR_W)) u_chk (.clock(clock),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin),
    .external_interrupt_0_pin(external_interrupt_0_pin),
    .external_interrupt_1_pin(external_interrupt_1_pin), .irq(irq));

/* dtc_pins.sv */
// dtc_pins.sv: far-side model of the count and gate pins
// assumes the bench asks for pulses and gate levels after clock edges
`timescale 1ns/100ps
module dtc_pins (
    input wire clock,
    input wire nrst,
    input wire [1:0] req,
    input wire [1:0] gate,
    output logic [1:0] cnt,
    output logic [1:0] gpin
);
    // idle high; one low cycle per request gives one falling edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 2'h3;
            gpin <= 2'h0;
        end else begin
            cnt <= ~req;
            gpin <= gate;
        end
    end
endmodule // dtc_pins

/* tb_top.sv */
// tb_top.sv: self-checking bench for dtc_timer_pair
// assumes dtc_pins drives the pins and dtc_chk is bound in
`timescale 1ns/100ps
module tb_top;
    logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, r;
    logic [1:0] req = 2'h0, gate = 2'h3;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [1:0] cnt, gpin;
    int n_mismatch = 0, comparisons = 0;
    always #50 clock = ~clock;
    dtc_timer_pair i_dut (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_count_pin(cnt[0]), .timer1_count_pin(cnt[1]),
        .external_interrupt_0_pin(gpin[0]),
        .external_interrupt_1_pin(gpin[1]), .irq(irq));
    dtc_pins i_pins (.clock(clock), .nrst(nrst), .req(req), .gate(gate),
        .cnt(cnt), .gpin(gpin));
    task chk(input [31:0] g, input [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task apb(input w, input [9:0] a, input [7:0] d);
        int k;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            $display("Error at %0t: pready %h expected %h", $time, pready,
                1'b1);
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input [9:0] a, input [31:0] x);
        apb(0, a, 8'h0);
        chk(r, x);
    endtask
    task t_regs;
        for (int i = 0; i < 5; i++) rd(10'h224 + 10'(4 * i), 0);
        for (int i = 0; i < 5; i++) begin
            apb(1, 10'h224 + 10'(4 * i), 8'ha5 ^ 8'(i));
            rd(10'h224 + 10'(4 * i), 8'ha5 ^ 8'(i));
        end
        rd(10'h3fc, 0);
        chk(e, 1);
        rd(10'h229, 0);
        chk(e, 1);
        $display("register test done");
    endtask
    task cnt_case(input t, input [3:0] f, input [1:0] g, input [7:0] lo,
        input [7:0] hi, input [3:0] n, input [7:0] elo, input [7:0] ehi,
        input [1:0] es);
        apb(1, 10'h280, 8'h0);
        apb(1, 10'h224, t ? {f, 4'h0} : {4'h0, f});
        apb(1, t ? 10'h22c : 10'h228, lo);
        apb(1, t ? 10'h234 : 10'h230, hi);
        gate <= g;
        apb(1, 10'h280, t ? 8'h2 : 8'h1);
        repeat (n) begin
            @(posedge clock);
            req[t] <= 1;
            @(posedge clock);
            req[t] <= 0;
        end
        repeat (3) @(posedge clock);
        apb(1, 10'h280, 8'h0);
        rd(t ? 10'h22c : 10'h228, elo);
        rd(t ? 10'h234 : 10'h230, ehi);
        rd(10'h284, es);
        $display("count case done t=%0d f=%h", t, f);
    endtask
    task t_rate(input t);
        apb(1, 10'h224, t ? 8'h10 : 8'h01);
        apb(1, t ? 10'h22c : 10'h228, 8'h0);
        apb(1, 10'h280, t ? 8'h2 : 8'h1);
        repeat (20) @(posedge clock);
        apb(1, 10'h280, 8'h0);
        apb(0, t ? 10'h22c : 10'h228, 8'h0);
        chk(32'(r >= 11 && r <= 12), 1);
        $display("rate test done t=%0d", t);
    endtask
    task t_split;
        logic [31:0] lo;
        apb(1, 10'h224, 8'h03);
        apb(1, 10'h228, 8'h0);
        apb(1, 10'h230, 8'hfe);
        apb(1, 10'h280, 8'h3);
        repeat (20) @(posedge clock);
        apb(1, 10'h280, 8'h0);
        apb(0, 10'h228, 8'h0);
        lo = r;
        chk(32'(lo >= 11 && lo <= 12), 1);
        rd(10'h230, {24'h0, lo[7:0] + 8'hfe});
        rd(10'h284, 2);
        $display("split test done");
    endtask
    task t_ovf(input m);
        apb(1, 10'h224, 8'h01);
        apb(1, 10'h288, {7'h0, m});
        apb(1, 10'h228, 8'hff);
        apb(1, 10'h230, 8'hff);
        apb(1, 10'h280, 8'h1);
        repeat (4) @(posedge clock);
        apb(1, 10'h280, 8'h0);
        chk(irq, m);
        rd(10'h284, 1);
        repeat (2) @(posedge clock);
        chk(irq, 0);
        $display("overflow test done mask=%0d", m);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1;
        t_regs;
        cnt_case(0, 4'h5, 2'h0, 8'hfe, 8'h0, 3, 8'h01, 8'h01, 0);
        cnt_case(1, 4'h5, 2'h0, 8'hfe, 8'h0, 3, 8'h01, 8'h01, 0);
        cnt_case(0, 4'h4, 2'h3, 8'h1f, 8'h7, 1, 8'h00, 8'h08, 0);
        cnt_case(1, 4'h4, 2'h3, 8'h1f, 8'h7, 1, 8'h00, 8'h08, 0);
        cnt_case(0, 4'h6, 2'h3, 8'hfe, 8'h40, 3, 8'h41, 8'h40, 1);
        cnt_case(1, 4'h6, 2'h3, 8'hfe, 8'h40, 3, 8'h41, 8'h40, 2);
        cnt_case(0, 4'hd, 2'h0, 8'h10, 8'h0, 2, 8'h10, 8'h00, 0);
        cnt_case(1, 4'hd, 2'h0, 8'h10, 8'h0, 2, 8'h10, 8'h00, 0);
        cnt_case(0, 4'hd, 2'h3, 8'h10, 8'h0, 2, 8'h12, 8'h00, 0);
        cnt_case(1, 4'hd, 2'h3, 8'h10, 8'h0, 2, 8'h12, 8'h00, 0);
        cnt_case(1, 4'h7, 2'h3, 8'h10, 8'h20, 2, 8'h10, 8'h20, 0);
        t_rate(0);
        t_rate(1);
        t_split;
        t_ovf(0);
        t_ovf(1);
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop;
    end
endmodule // tb_top
